// ===== rtl/fcr_pkg.sv
// package: constants and carriers for the flash configuration register block
package fcr_pkg;

    // link commands
    localparam logic [7:0] CMD_SET_READ_PARAMS_NV   = 8'h65;
    localparam logic [7:0] CMD_SET_READ_PARAMS_V_A  = 8'hC0;
    localparam logic [7:0] CMD_SET_READ_PARAMS_V_B  = 8'h63;
    localparam logic [7:0] CMD_WRITE_FUNCTION_REG   = 8'h42;
    localparam logic [7:0] CMD_READ_FUNCTION_REG    = 8'h48;
    localparam logic [7:0] CMD_READ_READ_PARAMS     = 8'h61;

    // function register fields
    localparam int FR_RESET_DISABLE_BIT = 0;
    localparam int FR_AREA_SELECT_BIT   = 1;
    localparam int FR_PROG_SUSP_BIT     = 2;
    localparam int FR_ERASE_SUSP_BIT    = 3;
    localparam int FR_ROW_LOCK_LSB      = 4;
    localparam logic [7:0] FR_OTP_MASK  = 8'hF3;
    localparam logic [7:0] FR_RESET     = 8'h00;

    // read parameter fields
    localparam int RP_SHARED_PIN_BIT = 7;
    localparam int RP_DUMMY_MSB      = 6;
    localparam int RP_DUMMY_LSB      = 3;
    localparam int RP_WRAP_EN_BIT    = 2;
    localparam int RP_BURST_MSB      = 1;
    localparam int RP_BURST_LSB      = 0;
    localparam logic [7:0] RP_RESET  = 8'h00;

    // block protection with 256KB blocks
    localparam int NUM_BLOCKS              = 512;
    localparam logic [3:0] PROTECT_ALL_MIN = 4'hA;
    localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;

    // link framing
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        FCR_OPCODE = 2'b00,
        FCR_WDATA  = 2'b01,
        FCR_RDATA  = 2'b11,
        FCR_IGNORE = 2'b10
    } fcr_state_e;

    // pin routing decisions
    typedef struct packed {
        logic reset_on_shared_pin;
        logic shared_pin_is_data3;
        logic protect_pin_is_data2;
        logic dedicated_reset_active;
    } fcr_pins_s;

    // read behaviour
    typedef struct packed {
        logic [3:0] dummy_cycles;
        logic       wrap_active;
        logic [6:0] wrap_bytes;
    } fcr_read_cfg_s;

    // protected block range
    typedef struct packed {
        logic       any;
        logic [8:0] first;
        logic [8:0] last;
    } fcr_range_s;

endpackage

// ===== rtl/fcr_regs.sv
// flash configuration: function register, read parameters, protection decode
//
// Operation
// [RL1] codes 1-9 protect power-of-two block count
// [RL2] codes 10-15 protect all, 0 none
// [RL3] one-time bits never return to zero
// [RL4] bit 0 moves reset to shared pin
// [RL5] bit 1 selects top or bottom area
// [RL6] program suspend flag follows suspend/resume
// [RL7] erase suspend flag follows suspend/resume
// [RL8] row lock bits refuse row programming
// [RL9] volatile params loaded from non-volatile copy
// [RL10] bit 7 picks pause or reset pin
// [RL11] quad or four-line makes pin data3
// [RL12] dedicated reset part keeps pause function
// [RL13] bits 6-3 give dummy cycle count
// [RL14] bit 2 enables burst wrapping
// [RL15] bits 1-0 give 8 to 64 bytes
// [RL16] each write command updates its copy only
// [RL17] wrap disabled reads whole array
// [RL18] quad enable makes protect pin data2
// [RL19] read-only and set bits ignore writes
`timescale 1ns/1ps
`default_nettype none
module fcr_regs
    import fcr_pkg::*;
#(
    parameter bit HAS_DEDICATED_RESET = 1'b1
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          sck,
    input  wire logic          cs_n,
    input  wire logic          si,
    output logic               so_o,
    output logic               so_oe,
    input  wire logic          reset_disable_strap,
    input  wire logic          power_up_load,
    input  wire logic          quad_enable,
    input  wire logic          four_line_command_mode,
    input  wire logic [3:0]    protect_level,
    input  wire logic          program_active,
    input  wire logic          erase_active,
    input  wire logic          suspend_cmd,
    input  wire logic          resume_cmd,
    input  wire logic          row_program_req,
    input  wire logic [1:0]    row_program_sel,
    output logic               row_program_refused,
    output logic [7:0]         function_reg,
    output logic [7:0]         read_params_nv,
    output logic [7:0]         read_params,
    output fcr_pins_s          pins,
    output fcr_read_cfg_s      read_cfg,
    output fcr_range_s         protect_range
);

    // link synchronisers; first stage feeds second only
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sck_prev_r;
    logic       sck_s;
    logic       cs_n_s;
    logic       si_s;
    logic       sck_rise;
    logic       sck_fall;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // idle link levels: clock low, select high, data low, so no false edge
            sync1_r    <= 3'h2;
            sync2_r    <= 3'h2;
            sck_prev_r <= 1'b0;
        end else begin
            sync1_r    <= {sck, cs_n, si};
            sync2_r    <= sync1_r;
            sck_prev_r <= sync2_r[2];
        end
    end

    assign sck_s    = sync2_r[2];
    assign cs_n_s   = sync2_r[1];
    assign si_s     = sync2_r[0];
    assign sck_rise = sck_s & ~sck_prev_r & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_r & ~cs_n_s;

    // register state
    fcr_state_e state_r, state_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] opcode_r, opcode_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic       so_r, so_nxt;
    logic       so_oe_r, so_oe_nxt;
    logic [7:0] fr_r, fr_nxt;
    logic [7:0] rp_nv_r, rp_nv_nxt;
    logic [7:0] rp_v_r, rp_v_nxt;
    logic       load_pending_r, load_pending_nxt;
    logic [7:0] byte_in;
    logic       byte_done;

    assign byte_in   = {shift_r[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_r == LAST_BIT);

    // command framing, register writes and flag tracking
    always_comb begin
        state_nxt        = state_r;
        bit_cnt_nxt      = bit_cnt_r;
        shift_nxt        = shift_r;
        opcode_nxt       = opcode_r;
        tx_nxt           = tx_r;
        so_nxt           = so_r;
        so_oe_nxt        = so_oe_r;
        fr_nxt           = fr_r;
        rp_nv_nxt        = rp_nv_r;
        rp_v_nxt         = rp_v_r;
        load_pending_nxt = 1'b0;

        // strap and non-volatile copy taken just after reset release
        if (load_pending_r) begin
            fr_nxt[FR_RESET_DISABLE_BIT] = fr_r[FR_RESET_DISABLE_BIT] | reset_disable_strap;
        end
        if (load_pending_r || power_up_load) begin
            rp_v_nxt = rp_nv_r; // [RL9]
        end

        if (cs_n_s) begin
            // frame end aborts any partial byte
            state_nxt   = FCR_OPCODE;
            bit_cnt_nxt = 3'h0;
            so_oe_nxt   = 1'b0;
        end else begin
            if (sck_rise) begin
                shift_nxt   = byte_in;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
                case (state_r)
                    FCR_OPCODE: begin
                        opcode_nxt = byte_in;
                        case (byte_in)
                            CMD_SET_READ_PARAMS_NV,
                            CMD_SET_READ_PARAMS_V_A,
                            CMD_SET_READ_PARAMS_V_B,
                            CMD_WRITE_FUNCTION_REG: state_nxt = FCR_WDATA;
                            CMD_READ_FUNCTION_REG: begin
                                state_nxt = FCR_RDATA;
                                tx_nxt    = fr_r;
                            end
                            CMD_READ_READ_PARAMS: begin
                                state_nxt = FCR_RDATA;
                                tx_nxt    = rp_v_r;
                            end
                            default: state_nxt = FCR_IGNORE;
                        endcase
                    end
                    FCR_WDATA: begin
                        state_nxt = FCR_IGNORE;
                        case (opcode_r)
                            CMD_SET_READ_PARAMS_NV: rp_nv_nxt = byte_in; // [RL16]
                            CMD_SET_READ_PARAMS_V_A,
                            CMD_SET_READ_PARAMS_V_B: rp_v_nxt = byte_in; // [RL16]
                            // one-time bits only ever gain ones; suspend flags untouched
                            default: fr_nxt = fr_nxt | (byte_in & FR_OTP_MASK); // [RL3] [RL19]
                        endcase
                    end
                    default: state_nxt = state_r;
                endcase
            end
            // read data shifted out msb first on falling edges, repeats per byte
            if (sck_fall && state_r == FCR_RDATA) begin
                so_nxt    = tx_r[7];
                tx_nxt    = {tx_r[6:0], tx_r[7]};
                so_oe_nxt = 1'b1;
            end
        end

        // suspend flags: set wins over resume in the same cycle
        if (resume_cmd) begin
            fr_nxt[FR_PROG_SUSP_BIT]  = 1'b0; // [RL6]
            fr_nxt[FR_ERASE_SUSP_BIT] = 1'b0; // [RL7]
        end
        if (suspend_cmd && program_active) begin
            fr_nxt[FR_PROG_SUSP_BIT] = 1'b1; // [RL6]
        end
        if (suspend_cmd && erase_active) begin
            fr_nxt[FR_ERASE_SUSP_BIT] = 1'b1; // [RL7]
        end
    end

    // registers only; nv copy models its reset value at power-on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r        <= FCR_OPCODE;
            bit_cnt_r      <= 3'h0;
            shift_r        <= 8'h00;
            opcode_r       <= 8'h00;
            tx_r           <= 8'h00;
            so_r           <= 1'b0;
            so_oe_r        <= 1'b0;
            fr_r           <= FR_RESET;
            rp_nv_r        <= RP_RESET;
            rp_v_r         <= RP_RESET;
            load_pending_r <= 1'b1;
        end else begin
            state_r        <= state_nxt;
            bit_cnt_r      <= bit_cnt_nxt;
            shift_r        <= shift_nxt;
            opcode_r       <= opcode_nxt;
            tx_r           <= tx_nxt;
            so_r           <= so_nxt;
            so_oe_r        <= so_oe_nxt;
            fr_r           <= fr_nxt;
            rp_nv_r        <= rp_nv_nxt;
            rp_v_r         <= rp_v_nxt;
            load_pending_r <= load_pending_nxt;
        end
    end

    assign so_o           = so_r;
    assign so_oe          = so_oe_r;
    assign function_reg   = fr_r;
    assign read_params_nv = rp_nv_r;
    assign read_params    = rp_v_r;

    // row lock check; combinational answer to the engine
    assign row_program_refused = row_program_req
        & fr_r[FR_ROW_LOCK_LSB + {30'h0, row_program_sel}]; // [RL8]

    // shared pin routing
    logic quad_lines;
    assign quad_lines = quad_enable | four_line_command_mode;

    always_comb begin
        pins.shared_pin_is_data3  = quad_lines; // [RL11]
        pins.protect_pin_is_data2 = quad_enable; // [RL18]
        if (HAS_DEDICATED_RESET) begin
            // strap bit decides whether reset leaves its own pin
            pins.dedicated_reset_active = ~fr_r[FR_RESET_DISABLE_BIT]; // [RL4]
            pins.reset_on_shared_pin    = ~quad_lines & fr_r[FR_RESET_DISABLE_BIT]; // [RL4] [RL12]
        end else begin
            pins.dedicated_reset_active = 1'b0;
            pins.reset_on_shared_pin    = ~quad_lines & rp_v_r[RP_SHARED_PIN_BIT]; // [RL10]
        end
    end

    // read behaviour from the working copy
    always_comb begin
        read_cfg.dummy_cycles = rp_v_r[RP_DUMMY_MSB:RP_DUMMY_LSB]; // [RL13]
        read_cfg.wrap_active  = rp_v_r[RP_WRAP_EN_BIT]; // [RL14] [RL17]
        read_cfg.wrap_bytes   = WRAP_BASE_BYTES << rp_v_r[RP_BURST_MSB:RP_BURST_LSB]; // [RL15]
    end

    // protected range: count is 2^(code-1), all from code 10 up
    logic [9:0] prot_count;
    always_comb begin
        if (protect_level == 4'h0) begin
            prot_count = 10'h000; // [RL2]
        end else if (protect_level >= PROTECT_ALL_MIN) begin
            prot_count = 10'(NUM_BLOCKS); // [RL2]
        end else begin
            prot_count = 10'h001 << (protect_level - 4'h1); // [RL1]
        end
        protect_range.any = (prot_count != 10'h000);
        if (prot_count == 10'h000) begin
            protect_range.first = 9'h000;
            protect_range.last  = 9'h000;
        end else if (fr_r[FR_AREA_SELECT_BIT]) begin
            protect_range.first = 9'h000; // [RL1] [RL5]
            protect_range.last  = 9'(prot_count - 10'h001);
        end else begin
            protect_range.first = 9'(10'(NUM_BLOCKS) - prot_count); // [RL1] [RL5]
            protect_range.last  = 9'(NUM_BLOCKS - 1);
        end
    end

endmodule // fcr_regs
`default_nettype wire

// ===== verification/fcr_host.sv
// host model: one mode 0 command frame on the serial link
`timescale 1ns/1ps
`default_nettype none
module fcr_host (
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    input wire logic so_o,
    input wire logic so_oe
);
    // idle link: clock parked low, select high
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // opcode then one byte, 800 ns bit time, read bit taken late in the high phase
    task automatic xfer(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] fr;
        fr = {op, wd};
        rd = 8'h00;
        #37 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            si = fr[i];
            #400 sck = 1'b1;
            #395 rd = {rd[6:0], so_o & so_oe};
            #5 sck = 1'b0;
        end
        #400 cs_n = 1'b1;
        si = ~si; // undriven line must not look like the old bit
        #1600;
    endtask
endmodule // fcr_host
`default_nettype wire

// ===== verification/fcr_regs_chk.sv
// checker: port assertions for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module fcr_regs_chk
    import fcr_pkg::*;
(
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          power_up_load,
    input wire logic          quad_enable,
    input wire logic          four_line_command_mode,
    input wire logic [3:0]    protect_level,
    input wire logic          program_active,
    input wire logic          erase_active,
    input wire logic          suspend_cmd,
    input wire logic          resume_cmd,
    input wire logic          row_program_req,
    input wire logic [1:0]    row_program_sel,
    input wire logic          row_program_refused,
    input wire logic [7:0]    function_reg,
    input wire logic [7:0]    read_params_nv,
    input wire logic [7:0]    read_params,
    input wire fcr_pins_s     pins,
    input wire fcr_read_cfg_s read_cfg,
    input wire fcr_range_s    protect_range
);
    // one clock domain, so clocking and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_dummy_wrap: assert property (read_cfg.dummy_cycles == read_params[6:3] && read_cfg.wrap_active == read_params[2])
        else $error("dummy or wrap decode wrong");
    a_burst_len: assert property (read_cfg.wrap_bytes == (7'h08 << read_params[1:0]))
        else $error("burst length decode wrong");
    a_otp_sticky: assert property (1'b1 |=> (function_reg & $past(function_reg) & FR_OTP_MASK) == ($past(function_reg) & FR_OTP_MASK))
        else $error("one-time bit fell back");
    a_program_suspended_flag_set: assert property (program_active && suspend_cmd |=> function_reg[2])
        else $error("program suspend flag not set");
    a_erase_suspended_flag_set: assert property (erase_active && suspend_cmd |=> function_reg[3])
        else $error("erase suspend flag not set");
    a_resume_clr: assert property (resume_cmd && !suspend_cmd |=> function_reg[3:2] == 2'b00)
        else $error("suspend flags not cleared");
    a_flags_hold: assert property (!suspend_cmd && !resume_cmd |=> $stable(function_reg[3:2]))
        else $error("suspend flags moved");
    a_row_refuse: assert property (row_program_req |-> row_program_refused == function_reg[4 + row_program_sel])
        else $error("row refusal wrong");
    a_data_pins: assert property (quad_enable || four_line_command_mode |-> pins.shared_pin_is_data3 && !pins.reset_on_shared_pin)
        else $error("shared pin not data line");
    a_protect_all: assert property (protect_level >= PROTECT_ALL_MIN |-> protect_range == {1'b1, 9'h000, 9'h1ff})
        else $error("high codes not all blocks");
    a_nv_load: assert property (power_up_load |=> read_params == $past(read_params_nv))
        else $error("volatile copy not loaded");
endmodule // fcr_regs_chk
bind fcr_regs fcr_regs_chk u_chk (.clk(clk), .rst_n(rst_n), .power_up_load(power_up_load),
    .quad_enable(quad_enable), .four_line_command_mode(four_line_command_mode), .protect_level(protect_level),
    .program_active(program_active), .erase_active(erase_active), .suspend_cmd(suspend_cmd),
    .resume_cmd(resume_cmd), .row_program_req(row_program_req), .row_program_sel(row_program_sel),
    .row_program_refused(row_program_refused), .function_reg(function_reg), .read_params_nv(read_params_nv),
    .read_params(read_params), .pins(pins), .read_cfg(read_cfg), .protect_range(protect_range));
`default_nettype wire

// ===== verification/fcr_regs_test.sv
// testbench: link writes and reads, protection decode, suspend flags, pin routing
`timescale 1ns/1ps
`default_nettype none
module fcr_regs_test;
    import fcr_pkg::*;
    logic               clk, rst_n, pul, qe, flm, pa, ea, sus, res, rreq, strap;
    logic [1:0]         rsel;
    logic [3:0]         pl;
    logic [7:0]         rd, v, w;
    logic [31:0]        lfsr, obs;
    logic [31:0]        exp_q[$];
    int                 error_cnt, tests_run;
    event               got;
    wire logic          sck, cs_n, si, so_o, so_oe, refused;
    wire logic [7:0]    fr, rp_nv, rp;
    wire fcr_pins_s     pins;
    wire fcr_read_cfg_s cfg;
    wire fcr_range_s    rng;

    fcr_regs dut (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
        .reset_disable_strap(strap), .power_up_load(pul), .quad_enable(qe), .four_line_command_mode(flm),
        .protect_level(pl), .program_active(pa), .erase_active(ea), .suspend_cmd(sus), .resume_cmd(res),
        .row_program_req(rreq), .row_program_sel(rsel), .row_program_refused(refused), .function_reg(fr),
        .read_params_nv(rp_nv), .read_params(rp), .pins(pins), .read_cfg(cfg), .protect_range(rng));
    fcr_host host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    initial begin
        #5_000_000;
        error_cnt++;
        complete_run();
    end
    // scoreboard: oldest note against each observed result
    initial forever begin
        @(got);
        check(obs, exp_q.pop_front());
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic strobe(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic expect_val(input logic [31:0] o, input logic [31:0] e);
        exp_q.push_back(e);
        obs = o;
        -> got;
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("summary: %0d compared, %0d unexpected", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // every protect code against the expected block range
    task automatic prot_sweep(input logic area);
        logic [8:0] n;
        for (int c = 0; c < 16; c++) begin
            pl = 4'(c);
            n = 9'h001 << (c - 1);
            #1;
            if (c == 0) expect_val(rng, 32'h0000_0000);
            else if (c >= 10) expect_val(rng, {1'b1, 9'h000, 9'h1ff});
            else if (area) expect_val(rng, {1'b1, 9'h000, n - 9'h001});
            else expect_val(rng, {1'b1, 9'h1ff - n + 9'h001, 9'h1ff});
        end
    endtask
    // all quad and four-line combinations
    task automatic pin_sweep(input logic b0);
        for (int k = 0; k < 4; k++) begin
            {qe, flm} = 2'(k);
            tick(1);
            expect_val(pins, {b0 & ~qe & ~flm, qe | flm, qe, ~b0});
        end
        {qe, flm} = 2'b00;
    endtask

    // main sequence
    initial begin
        {rst_n, pul, qe, flm, pa, ea, sus, res, rreq} = 9'h000;
        rsel = 2'h0;
        strap = 1'b0;
        pl = 4'h0;
        w = 8'h00;
        lfsr = 32'h0000_fb9d;
        obs = 32'h0000_0000;
        tick(6);
        rst_n = 1'b1;
        tick(3);
        expect_val({fr, rp_nv, rp}, 32'h0000_0000);
        $display("done: reset values");
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            v = {lfsr[7:2], 2'(i)};
            host.xfer(CMD_SET_READ_PARAMS_NV, v, rd);
            expect_val({rp_nv, rp}, {v, w});
            strobe(pul);
            expect_val({rp, cfg}, {v, v[6:3], v[2], 7'h08 << v[1:0]});
            w = ~v;
            host.xfer(i[0] ? CMD_SET_READ_PARAMS_V_B : CMD_SET_READ_PARAMS_V_A, w, rd);
            host.xfer(CMD_READ_READ_PARAMS, 8'h00, rd);
            expect_val({rp_nv, rd, cfg}, {v, w, w[6:3], w[2], 7'h08 << w[1:0]});
        end
        $display("done: read parameters");
        pa = 1'b1;
        strobe(sus);
        pa = 1'b0;
        host.xfer(CMD_WRITE_FUNCTION_REG, 8'h08, rd);
        expect_val(fr, 8'h04);
        strobe(res);
        expect_val(fr, 8'h00);
        ea = 1'b1;
        strobe(sus);
        ea = 1'b0;
        expect_val(fr, 8'h08);
        strobe(res);
        expect_val(fr, 8'h00);
        $display("done: suspend flags");
        prot_sweep(1'b0);
        host.xfer(CMD_SET_READ_PARAMS_V_A, 8'h80, rd);
        pin_sweep(1'b0);
        host.xfer(CMD_WRITE_FUNCTION_REG, 8'h12, rd);
        for (int s = 0; s < 4; s++) begin
            rsel = 2'(s);
            rreq = 1'b1;
            #1;
            expect_val(refused, s == 0);
        end
        rreq = 1'b0;
        host.xfer(CMD_WRITE_FUNCTION_REG, 8'h00, rd);
        host.xfer(CMD_READ_FUNCTION_REG, 8'h00, rd);
        expect_val({fr, rd}, 16'h1212);
        prot_sweep(1'b1);
        host.xfer(CMD_WRITE_FUNCTION_REG, 8'h13, rd);
        pin_sweep(1'b1);
        $display("done: function register, protection, pins");
        // second reset with the package strap set: bit 0 comes up one
        strap = 1'b1;
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(3);
        expect_val({fr, rp, pins}, {8'h01, 8'h00, 4'h8});
        $display("done: strap after reset");
        complete_run();
    end
endmodule // fcr_regs_test
`default_nettype wire
